// ===== hw/fwsr_pkg.sv
// Package of constants for the flash write-status polling host controller.
package fwsr_pkg;

   // ************************************************************
   // Data bus bit positions of the status bits
   // ************************************************************
   localparam int POLL_COMPLEMENT_POS = 7; // Complement of programmed datum.
   localparam int TOGGLE_ANY_POS = 6; // Toggles on every read while busy.
   localparam int TIMEOUT_FAIL_POS = 5; // High when the pulse count limit ran out.
   localparam int ERASE_WINDOW_POS = 3; // Low during sector erase acceptance window.
   localparam int TOGGLE_SECTOR_POS = 2; // Toggles inside sectors selected for erase.

   // ************************************************************
   // Commands and bus timing
   // ************************************************************
   localparam logic [7:0] CMD_RESET = 8'hF0; // Single write to any address.
   localparam logic [3:0] STROBE_CYCLES = 4'h4; // Cycles a strobe is held low.
   localparam logic [3:0] SETUP_CYCLES = 4'h2; // Cycles before and after a strobe.

   // Result codes reported to the user side.
   localparam logic [1:0] RESULT_NONE = 2'h0;
   localparam logic [1:0] RESULT_DONE = 2'h1;
   localparam logic [1:0] RESULT_FAIL = 2'h2;
   localparam logic [1:0] RESULT_ABORT = 2'h3;

   // Controller states, one-hot.
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_READ_A = 7'h02,
      ST_READ_B = 7'h04,
      ST_READ_C = 7'h08,
      ST_RESET_WR = 7'h10,
      ST_WRITE = 7'h20,
      ST_DONE = 7'h40
   } fwsr_state_type;

endpackage : fwsr_pkg

// ===== hw/fwsr_host.sv
// Host controller that writes the flash and polls its toggle status to completion.
`timescale 1ns/1ps

// Behaviour
// - Host reads twice, compares toggle bit
// - Timeout high: recheck; still toggling means reset
// - Returning host restarts polling from start
// - Host writes reset after any timeout failure
// - Ignore window bit only under 50 us spacing
// - Check window bit around added sector erases
// - Host gives valid address for status reads
// - Reset is F0 written anywhere
module fwsr_host #(
   parameter int ADDR_W = 19 // Flash address width.
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic wr_req, // Pulse: write one byte (command cycle).
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic poll_req, // Pulse: poll an operation to completion.
   input wire logic [ADDR_W-1:0] poll_addr,
   input wire logic abort_req, // Level, sampled only in ST_READ_C: hold high until a read pair ends to leave polling for other work.
   input wire logic win_req, // Pulse: single read to sample the erase window bit.
   output logic busy,
   output logic done, // Pulse: a request finished.
   output logic [1:0] result,
   output logic [7:0] status_byte, // Last byte read from the flash.
   output logic erase_window_bit, // Erase window bit of that byte.
   output logic toggle_sector_bit, // Sector toggle seen across two reads.
   output logic [ADDR_W-1:0] flash_addr,
   input wire logic [7:0] flash_dq_in,
   output logic [7:0] flash_dq_out,
   output logic flash_dq_oe,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n
);
   import fwsr_pkg::*;

   fwsr_state_type state_reg; // Current controller state.
   fwsr_state_type after_reg; // State to enter after the current bus cycle.
   logic [3:0] cnt_reg; // Bus cycle phase counter.
   logic cyc_reg; // A bus cycle is in flight.
   logic cyc_wr_reg; // Current bus cycle is a write.
   logic [7:0] first_reg; // Byte from the first read of a pair.
   logic [7:0] second_reg; // Byte from the second read of a pair.
   logic win_only_reg; // Current read is a single window sample.

   // Full length of one bus cycle: setup, strobe, hold.
   localparam logic [3:0] CYC_LEN = 4'(SETUP_CYCLES + STROBE_CYCLES + SETUP_CYCLES);

   // Returns whether the any-address toggle bit differs between two bytes.
   function automatic logic toggled(input logic [7:0] a, input logic [7:0] b);
      toggled = a[TOGGLE_ANY_POS] ^ b[TOGGLE_ANY_POS];
   endfunction : toggled

   // ************************************************************
   // Bus cycle engine
   // ************************************************************

   // Drives the strobes of one read or write cycle; strobes stay high outside cycles.
   // The flash has no clock, so every strobe edge is spaced by whole setup counts.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cnt_reg <= 4'h0;
         flash_ce_n <= 1'b1;
         flash_oe_n <= 1'b1;
         flash_we_n <= 1'b1;
         flash_dq_oe <= 1'b0;
      end else if (clk_en && cyc_reg) begin
         cnt_reg <= (cnt_reg == CYC_LEN) ? 4'h0 : cnt_reg + 4'h1;
         // Chip select spans the whole cycle so each read is a distinct cycle.
         flash_ce_n <= (cnt_reg == CYC_LEN);
         flash_dq_oe <= cyc_wr_reg && (cnt_reg != CYC_LEN);
         if (cnt_reg == SETUP_CYCLES) begin
            flash_oe_n <= cyc_wr_reg;
            flash_we_n <= !cyc_wr_reg;
         end else if (cnt_reg == 4'(SETUP_CYCLES + STROBE_CYCLES)) begin
            // status valid
            // Rising write edge ends the sequence; status reads may follow.
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
         end
      end
   end

   // ************************************************************
   // Polling sequencer
   // ************************************************************

   // Walks the toggle algorithm and reset recovery.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         after_reg <= ST_IDLE;
         cyc_reg <= 1'b0;
         cyc_wr_reg <= 1'b0;
         first_reg <= 8'h00;
         second_reg <= 8'h00;
         win_only_reg <= 1'b0;
         busy <= 1'b0;
         done <= 1'b0;
         result <= RESULT_NONE;
         status_byte <= 8'h00;
         erase_window_bit <= 1'b0;
         toggle_sector_bit <= 1'b0;
         flash_addr <= '0;
         flash_dq_out <= 8'h00;
      end else if (clk_en) begin
         done <= 1'b0;
         // Read data is captured at the rising edge of the read strobe.
         if (cyc_reg && !cyc_wr_reg && cnt_reg == 4'(SETUP_CYCLES + STROBE_CYCLES)) begin
            status_byte <= flash_dq_in;
            erase_window_bit <= flash_dq_in[ERASE_WINDOW_POS];
         end
         if (cyc_reg && cnt_reg == CYC_LEN) begin
            cyc_reg <= 1'b0;
            state_reg <= after_reg;
         end
         case (state_reg)
            ST_IDLE: begin
               // Idle: one request at a time, priority write, poll, window.
               if (wr_req) begin
                  flash_addr <= wr_addr;
                  flash_dq_out <= wr_data;
                  cyc_wr_reg <= 1'b1;
                  cyc_reg <= 1'b1;
                  busy <= 1'b1;
                  state_reg <= ST_WRITE;
                  after_reg <= ST_DONE;
                  result <= RESULT_DONE;
               end else if (poll_req || win_req) begin
                  // valid address
                  // The user gives the programmed or erasing-sector address.
                  flash_addr <= poll_addr;
                  cyc_wr_reg <= 1'b0;
                  cyc_reg <= 1'b1;
                  busy <= 1'b1;
                  win_only_reg <= win_req && !poll_req;
                  state_reg <= ST_READ_A;
                  after_reg <= ST_READ_B;
               end
            end
            ST_READ_B: begin
               // double read
               // First byte of the pair is held; start the second read.
               if (win_only_reg) begin
                  // window check
                  // One read is enough; the user compares the bit around each added erase.
                  result <= RESULT_DONE;
                  state_reg <= ST_DONE;
               end else if (!cyc_reg) begin
                  first_reg <= status_byte;
                  cyc_reg <= 1'b1;
                  state_reg <= ST_READ_A;
                  after_reg <= ST_READ_C;
               end
            end
            ST_READ_C: begin
               // restart polling
               // Abort clears the second stored byte; the next poll reloads the first and starts fresh.
               second_reg <= status_byte;
               toggle_sector_bit <= first_reg[TOGGLE_SECTOR_POS] ^ status_byte[TOGGLE_SECTOR_POS];
               if (abort_req) begin
                  result <= RESULT_ABORT;
                  state_reg <= ST_DONE;
               end else if (!toggled(first_reg, status_byte)) begin
                  result <= RESULT_DONE;
                  state_reg <= ST_DONE;
               end else if (first_reg[TIMEOUT_FAIL_POS] && second_reg[TIMEOUT_FAIL_POS]) begin
                  // recheck failed
                  // Timeout seen, and the recheck pair still toggles.
                  result <= RESULT_FAIL;
                  state_reg <= ST_RESET_WR;
               end else begin
                  // recheck toggling
                  // Take one fresh read; the timeout bit of this pair's last read arms failure.
                  first_reg <= status_byte;
                  second_reg <= status_byte;
                  cyc_reg <= 1'b1;
                  state_reg <= ST_READ_A;
                  after_reg <= ST_READ_C;
               end
            end
            ST_RESET_WR: begin
               flash_dq_out <= CMD_RESET;
               cyc_wr_reg <= 1'b1;
               cyc_reg <= 1'b1;
               state_reg <= ST_WRITE;
               after_reg <= ST_DONE;
            end
            ST_DONE: begin
               // Report completion and return to idle.
               busy <= 1'b0;
               done <= 1'b1;
               cyc_wr_reg <= 1'b0;
               win_only_reg <= 1'b0;
               second_reg <= 8'h00;
               state_reg <= ST_IDLE;
            end
            ST_READ_A, ST_WRITE: begin
               // Waiting for the bus cycle engine.
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

endmodule : fwsr_host

// ===== tb/fwsr_host_checker.sv
// Checker of the flash polling host controller's bus cycles and results.
`timescale 1ns/1ps
module fwsr_host_checker #(
   parameter int ADDR_W = 19 // Flash address width.
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic busy,
   input wire logic done,
   input wire logic [1:0] result,
   input wire logic [ADDR_W-1:0] flash_addr,
   input wire logic [7:0] flash_dq_out,
   input wire logic flash_dq_oe,
   input wire logic flash_ce_n,
   input wire logic flash_oe_n,
   input wire logic flash_we_n
);
   import fwsr_pkg::*;
   logic [7:0] rd_cnt; // Reads since the request was taken.
   logic [7:0] last_wr; // Last byte written to the flash.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Counts reads; it restarts in idle, so each request counts its own reads.
   always_ff @(posedge ref_clk) begin
      if (!rst_n || !busy) begin
         rd_cnt <= 8'h00;
      end else if ($fell(flash_oe_n)) begin
         rd_cnt <= rd_cnt + 8'h01;
      end
   end
   // Keeps the byte of the latest write strobe.
   always_ff @(posedge ref_clk) begin
      if (!flash_we_n) begin
         last_wr <= flash_dq_out;
      end
   end
   AST_RESET_IDLE: assert property (disable iff (1'b0) !rst_n |=> flash_ce_n && flash_oe_n
      && flash_we_n && !busy) else $error("bus not idle after reset");
   AST_OE_NO_DRIVE: assert property (!flash_oe_n |-> !flash_dq_oe)
      else $error("host drives data during a read");
   AST_DONE_PULSE: assert property (done |=> !done) else $error("done longer than one cycle");
   AST_RD_WIDTH: assert property ($fell(flash_oe_n) |-> !flash_oe_n [*4] ##1 flash_oe_n)
      else $error("read strobe width wrong");
   AST_ADDR_STABLE: assert property (!flash_ce_n && !$past(flash_ce_n)
      |-> $stable(flash_addr)) else $error("address moved inside a bus cycle");
   AST_WE_DATA: assert property (!flash_we_n |-> flash_dq_oe && $stable(flash_dq_out))
      else $error("write data not held under strobe");
   AST_FAIL_RESET: assert property (done && result == RESULT_FAIL
      |-> last_wr == CMD_RESET) else $error("failure without reset command");
   // The recheck compares one fresh read with the last read of the toggling pair.
   AST_FAIL_READS: assert property (done && result == RESULT_FAIL |-> rd_cnt >= 8'h03)
      else $error("failure decided without recheck");
   AST_ABORT_READS: assert property (done && result == RESULT_ABORT |-> rd_cnt >= 8'h02)
      else $error("abort before a read pair");
endmodule : fwsr_host_checker
bind fwsr_host fwsr_host_checker #(.ADDR_W(ADDR_W)) i_chk (.ref_clk(ref_clk), .rst_n(rst_n),
   .busy(busy), .done(done), .result(result), .flash_addr(flash_addr),
   .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
   .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));

// ===== tb/fwsr_flash_model.sv
// Behavioural flash that answers reads with write-operation status bytes.
`timescale 1ns/1ps
module fwsr_flash_model (
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic [7:0] dq_w,
   input wire logic dq_oe,
   output logic [7:0] dq_r
);
   import fwsr_pkg::*;
   localparam logic [7:0] SUSPEND_CMD = 8'hB0; // Erase suspend, still taken while erasing.
   int busy_reads = 0; // Status reads left before the operation ends.
   logic fail = 1'b0; // Pulse count limit ran out, set by the bench.
   logic win = 1'b0; // Erase window bit value.
   logic t6 = 1'b0; // Any-address toggle state.
   logic t2 = 1'b0; // Sector toggle state.
   logic [7:0] last_wr = 8'h00; // Last byte written.
   initial dq_r = 8'hA5;
   always @(negedge oe_n) begin
      if (!ce_n && (busy_reads > 0 || fail)) begin
         t6 = ~t6;
         t2 = ~t2;
         busy_reads = (busy_reads > 0) ? busy_reads - 1 : 0;
         dq_r = {1'b0, t6, fail, 1'b0, win, t2, 2'b00};
      end else if (!ce_n) begin
         dq_r = 8'h5A; // Array data once the operation ends.
      end
   end
   // No pull on the bus, so a released bus shows the inverse of the last value.
   always @(posedge oe_n) dq_r = ~dq_r;
   // window closed.
   // Once erasing has begun, every write other than suspend is dropped.
   always @(posedge we_n) begin
      if (!ce_n && dq_oe && !(win && busy_reads > 0 && dq_w != SUSPEND_CMD)) begin
         last_wr = dq_w;
         if (dq_w == CMD_RESET) begin
            fail = 1'b0;
            busy_reads = 0;
         end
      end
   end
endmodule : fwsr_flash_model

// ===== tb/tb_top.sv
// Testbench of the flash polling host controller against a status flash model.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_top;
   import fwsr_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n, clk_en, wr_req, poll_req, abort_req, win_req, busy, done;
   logic [18:0] wr_addr, poll_addr, flash_addr;
   logic [7:0] wr_data, status_byte, dq_in, dq_out;
   logic [1:0] result;
   logic erase_window_bit, toggle_sector_bit, dq_oe, ce_n, oe_n, we_n;
   int mismatches = 0;
   int n_tests = 0;
   int cycles = 0;
   fwsr_host i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .wr_req(wr_req),
      .wr_addr(wr_addr), .wr_data(wr_data), .poll_req(poll_req), .poll_addr(poll_addr),
      .abort_req(abort_req), .win_req(win_req), .busy(busy), .done(done), .result(result),
      .status_byte(status_byte), .erase_window_bit(erase_window_bit),
      .toggle_sector_bit(toggle_sector_bit), .flash_addr(flash_addr), .flash_dq_in(dq_in),
      .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
      .flash_we_n(we_n));
   fwsr_flash_model i_flash (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_w(dq_out),
      .dq_oe(dq_oe), .dq_r(dq_in));
   always #12.5 ref_clk = ~ref_clk;
   // Cuts a hang short; the tests need a few hundred cycles.
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   // Issues one request at a clock edge and waits, bounded, for its done pulse.
   task automatic run(input logic w, input logic p, input logic v, input logic [18:0] a,
      input logic [7:0] d);
      int n;
      n = 0;
      wr_req <= w;
      poll_req <= p;
      win_req <= v;
      wr_addr <= a;
      poll_addr <= a;
      wr_data <= d;
      @(posedge ref_clk);
      wr_req <= 1'b0;
      poll_req <= 1'b0;
      win_req <= 1'b0;
      while (done !== 1'b1 && n < 3000) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 3000) begin
         mismatches++;
         give_verdict();
      end
   endtask : run
   initial begin
      {rst_n, wr_req, poll_req, abort_req, win_req, wr_addr, poll_addr, wr_data} = '0;
      clk_en = 1'b1;
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      // A byte other than the reset code, so the failure test proves its own reset write.
      run(1'b1, 1'b0, 1'b0, 19'h00555, 8'hAA);
      `CHK("written byte", 8'hAA, i_flash.last_wr)
      $display("test write finished");
      // Ends on a status byte whose toggle bit differs from array data: one extra read.
      i_flash.busy_reads = 4;
      run(1'b0, 1'b1, 1'b0, 19'h12345, 8'h00);
      `CHK("poll result", RESULT_DONE, result)
      `CHK("busy after done", 1'b0, busy)
      `CHK("array byte", 8'h5A, status_byte)
      `CHK("sector toggle", 1'b0, toggle_sector_bit)
      $display("test poll finished");
      i_flash.fail = 1'b1;
      run(1'b0, 1'b1, 1'b0, 19'h20000, 8'h00);
      `CHK("fail result", RESULT_FAIL, result)
      `CHK("reset byte", CMD_RESET, i_flash.last_wr)
      `CHK("reset address", 19'h20000, flash_addr)
      `CHK("fail cleared", 1'b0, i_flash.fail)
      $display("test failure finished");
      i_flash.busy_reads = 200;
      abort_req <= 1'b1;
      run(1'b0, 1'b1, 1'b0, 19'h30000, 8'h00);
      abort_req <= 1'b0;
      `CHK("abort result", RESULT_ABORT, result)
      `CHK("sector toggle", 1'b1, toggle_sector_bit)
      i_flash.busy_reads = 4;
      run(1'b0, 1'b1, 1'b0, 19'h30000, 8'h00);
      `CHK("restart result", RESULT_DONE, result)
      $display("test abort finished");
      for (int k = 0; k < 2; k++) begin
         i_flash.busy_reads = 2;
         i_flash.win = k[0];
         run(1'b0, 1'b0, 1'b1, 19'h30000, 8'h00);
         `CHK("window bit", k[0], erase_window_bit)
      end
      $display("test window finished");
      give_verdict();
   end
endmodule : tb_top
